// file: verilog/clb_pkg.sv
package clb_pkg;

  // Bus and address widths of the local bus.
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int WORD_LSB = 2;
  localparam int WADDR_W = DATA_W - WORD_LSB;

  // Real-mode segment arithmetic.
  localparam int SEG_W = 16;
  localparam int SEG_LSB = 16;
  localparam int SEG_SHIFT = 4;
  localparam int REAL_W = 20;
  localparam logic [DATA_W-REAL_W-1:0] REAL_HI_ZERO = 12'h000;

  // Data port of the numeric coprocessor in I/O space.
  localparam logic [DATA_W-1:0] COPRO_DATA_PORT = 32'h800000FC;
  localparam logic [BE_W-1:0] BE_ALL = 4'hF;

  // Cycle-type encodings on the select outputs.
  localparam logic SEL_MEM = 1'b1;
  localparam logic SEL_IO = 1'b0;
  localparam logic SEL_DATA = 1'b1;
  localparam logic SEL_CTRL = 1'b0;

  typedef enum logic [1:0] {
    CLB_IDLE = 2'h0,
    CLB_T1 = 2'h1,
    CLB_T2 = 2'h2,
    CLB_HOLD = 2'h3
  } clb_state_t;

  // One bus request from the core.
  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
    logic write;
    logic mem;
    logic data;
    logic lock;
  } clb_req_t;

  // Pin inputs, as seen after the synchroniser.
  typedef struct packed {
    logic ready_n;
    logic hold;
    logic intr;
    logic nmi;
    logic opreq;
    logic busy_n;
    logic error_n;
    logic [DATA_W-1:0] data;
  } clb_pin_in_t;

  localparam int PIN_IN_W = $bits(clb_pin_in_t);

  // Idle levels of the pin inputs. The synchroniser starts from these, so
  // no active-low input looks asserted for the first clocks after reset.
  localparam clb_pin_in_t PIN_IDLE = '{ready_n: 1'b1, busy_n: 1'b1,
                                       error_n: 1'b1, default: '0};

  // Whole state of the bus unit.
  typedef struct packed {
    logic ph;
    clb_state_t state;
    clb_req_t cur;
    logic [DATA_W-1:0] phys;
    logic is_copro;
    logic lock_q;
    logic prot;
    logic nmi_prev;
    logic nmi_pend;
    logic intr_seen;
    logic intr_take;
    logic nmi_take;
    logic rsp_valid;
    logic copro_done;
    logic [DATA_W-1:0] rdata;
    logic grant;
  } clb_biu_st_t;

  localparam clb_biu_st_t BIU_RST = '0;

endpackage : clb_pkg

// file: verilog/clb_sync.sv
`timescale 1ns/1ns
module clb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } clb_sync_st_t;

  clb_sync_st_t st_q;
  clb_sync_st_t st_d;

  // The first stage feeds only the second, so metastability stays inside.
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule : clb_sync

// file: verilog/clb_real_addr.sv
`timescale 1ns/1ns
module clb_real_addr (
  input wire logic [clb_pkg::SEG_W-1:0] seg,
  input wire logic [clb_pkg::SEG_W-1:0] off,
  output logic [clb_pkg::REAL_W-1:0] phys
);

  // The sum is kept at the real-mode width, so it wraps inside one megabyte.
  assign phys = {seg, {clb_pkg::SEG_SHIFT{1'b0}}}
              + clb_pkg::REAL_W'(off);

endmodule : clb_real_addr

// file: verilog/clb_bus_unit.sv
`timescale 1ns/1ns
module clb_bus_unit (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire clb_pkg::clb_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [clb_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic enter_protected,
  output logic real_mode,
  input wire logic insn_boundary,
  input wire logic intr_enable,
  output logic intr_take,
  output logic nmi_take,
  input wire logic copro_xfer_write,
  input wire logic [clb_pkg::DATA_W-1:0] copro_wdata,
  output logic copro_xfer_done,
  output logic core_stall,
  output logic copro_error,
  output logic proc_phase,
  input wire logic bus_ready_n,
  input wire logic hold_request,
  input wire logic intr_request,
  input wire logic nmi_request,
  input wire logic copro_operand_request,
  input wire logic copro_busy_n,
  input wire logic copro_error_n,
  input wire logic [clb_pkg::DATA_W-1:0] data_in,
  output logic [clb_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [clb_pkg::WADDR_W-1:0] word_addr,
  output logic [clb_pkg::BE_W-1:0] byte_lane_enables_n,
  output logic cycle_start_strobe_n,
  output logic mem_io_sel,
  output logic data_ctrl_sel,
  output logic write_read_sel,
  output logic bus_lock_n,
  output logic ctrl_oe,
  output logic bus_ownership_grant
);

  // True while a bus cycle owns the pins.
  function automatic logic in_cycle(input clb_pkg::clb_state_t s);
    in_cycle = (s == clb_pkg::CLB_T1) || (s == clb_pkg::CLB_T2);
  endfunction : in_cycle

  clb_pkg::clb_biu_st_t st_q;
  clb_pkg::clb_biu_st_t st_d;
  clb_pkg::clb_pin_in_t pin;
  logic [clb_pkg::PIN_IN_W-1:0] pin_raw;
  logic [clb_pkg::PIN_IN_W-1:0] pin_sync;
  logic [clb_pkg::REAL_W-1:0] real_phys;
  logic ph_en;
  clb_pkg::clb_req_t pick;
  logic pick_copro;
  logic core_go;
  logic [clb_pkg::DATA_W-1:0] pick_phys;

  // Every pin input, the data bus included, goes through two flops so that
  // the sampled data stays aligned with the sampled termination input.
  assign pin_raw = {bus_ready_n, hold_request, intr_request, nmi_request,
                    copro_operand_request, copro_busy_n, copro_error_n,
                    data_in};

  clb_sync #(
    .W(clb_pkg::PIN_IN_W),
    .RST_VAL(clb_pkg::PIN_IDLE)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d(pin_raw),
    .q(pin_sync)
  );

  assign pin = pin_sync;

  // Real-mode address of the core's request, segment in the upper half.
  clb_real_addr u_real (
    .seg(req.addr[clb_pkg::SEG_LSB +: clb_pkg::SEG_W]),
    .off(req.addr[clb_pkg::SEG_W-1:0]),
    .phys(real_phys)
  );

  // Processing-cycle edge: every second enabled clock.
  assign ph_en = clk_en && st_q.ph;

  // A pending operand request outranks the core; the coprocessor port is a
  // fixed I/O data cycle and bypasses real-mode arithmetic.
  always_comb begin
    pick_copro = pin.opreq;
    core_go = req_valid && pin.busy_n;
    pick = req;
    pick_phys = st_q.prot ? req.addr
                          : {clb_pkg::REAL_HI_ZERO, real_phys};
    if (pick_copro) begin
      pick.addr = clb_pkg::COPRO_DATA_PORT;
      pick.wdata = copro_wdata;
      pick.be = clb_pkg::BE_ALL;
      pick.write = copro_xfer_write;
      pick.mem = clb_pkg::SEL_IO;
      pick.data = clb_pkg::SEL_DATA;
      pick.lock = 1'b0;
      pick_phys = clb_pkg::COPRO_DATA_PORT;
    end
  end

  // Next state. The bus sequencer and interrupt sampling move only on the
  // processing-cycle edge; the NMI edge detector watches every clock so a
  // short pulse is not missed.
  always_comb begin
    st_d = st_q;
    req_ready = 1'b0;
    if (clk_en) begin
      st_d.ph = ~st_q.ph;
      st_d.intr_take = 1'b0;
      st_d.nmi_take = 1'b0;
      st_d.rsp_valid = 1'b0;
      st_d.copro_done = 1'b0;
      st_d.nmi_prev = pin.nmi;
      if (enter_protected) begin
        st_d.prot = 1'b1;
      end
      if (st_q.ph) begin
        st_d.intr_seen = pin.intr;
        if (insn_boundary) begin
          if (st_q.nmi_pend) begin
            st_d.nmi_take = 1'b1;
            st_d.nmi_pend = 1'b0;
          end else if (st_q.intr_seen && intr_enable) begin
            st_d.intr_take = 1'b1;
          end
        end
        case (st_q.state)
          clb_pkg::CLB_IDLE: begin
            // A held lock keeps the bus; hold waits for the sequence end.
            if (pin.hold && !st_q.lock_q) begin
              st_d.state = clb_pkg::CLB_HOLD;
              st_d.grant = 1'b1;
            end else if (!pin.hold && (pick_copro || core_go)) begin
              req_ready = !pick_copro;
              st_d.state = clb_pkg::CLB_T1;
              st_d.cur = pick;
              st_d.phys = pick_phys;
              st_d.is_copro = pick_copro;
              st_d.lock_q = st_q.lock_q || pick.lock;
            end else if (pin.hold) begin
              // Locked and requested: the next cycle of the sequence
              // may still run, the grant follows when the lock drops.
              if (pick_copro || core_go) begin
                req_ready = !pick_copro;
                st_d.state = clb_pkg::CLB_T1;
                st_d.cur = pick;
                st_d.phys = pick_phys;
                st_d.is_copro = pick_copro;
              end
            end
          end
          clb_pkg::CLB_T1: begin
            st_d.state = clb_pkg::CLB_T2;
          end
          clb_pkg::CLB_T2: begin
            if (!pin.ready_n) begin
              st_d.state = clb_pkg::CLB_IDLE;
              st_d.rsp_valid = !st_q.is_copro;
              st_d.copro_done = st_q.is_copro;
              st_d.lock_q = st_q.cur.lock;
              if (!st_q.cur.write) begin
                st_d.rdata = pin.data;
              end
            end
          end
          clb_pkg::CLB_HOLD: begin
            if (!pin.hold) begin
              st_d.state = clb_pkg::CLB_IDLE;
              st_d.grant = 1'b0;
            end
          end
          default: begin
            st_d.state = clb_pkg::CLB_IDLE;
          end
        endcase
      end
      // A new edge wins over the clear at the boundary above.
      if (pin.nmi && !st_q.nmi_prev) begin
        st_d.nmi_pend = 1'b1;
      end
    end
  end

  // Reset clears everything, real mode included; work starts on release.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= clb_pkg::BIU_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Pin outputs come from state flops only; data_oe and cycle_start_strobe_n are decoded from the state.
  assign data_out = st_q.cur.wdata;
  assign data_oe = in_cycle(st_q.state) && st_q.cur.write;
  assign word_addr = st_q.phys[clb_pkg::DATA_W-1:clb_pkg::WORD_LSB];
  assign byte_lane_enables_n = ~st_q.cur.be;
  assign cycle_start_strobe_n = (st_q.state != clb_pkg::CLB_T1);
  assign mem_io_sel = st_q.cur.mem;
  assign data_ctrl_sel = st_q.cur.data;
  assign write_read_sel = st_q.cur.write;
  assign bus_lock_n = ~st_q.lock_q;
  assign ctrl_oe = !st_q.grant;
  assign bus_ownership_grant = st_q.grant;

  // Core-side results.
  assign rsp_valid = st_q.rsp_valid;
  assign rsp_rdata = st_q.rdata;
  assign copro_xfer_done = st_q.copro_done;
  assign intr_take = st_q.intr_take;
  assign nmi_take = st_q.nmi_take;
  assign real_mode = !st_q.prot;
  assign proc_phase = st_q.ph;
  // Busy and error are levels; the core decides what to do at a boundary.
  assign core_stall = !pin.busy_n;
  assign copro_error = !pin.error_n;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_start;
    $fell(cycle_start_strobe_n);
  endsequence

  sequence s_wait;
    ph_en && st_q.state == clb_pkg::CLB_T2 && pin.ready_n;
  endsequence

  phase_toggle_a: assert property (
    clk_en |=> proc_phase != $past(proc_phase))
    else $error("Processing phase did not toggle.");

  data_dir_a: assert property (
    data_oe |-> write_read_sel && !bus_ownership_grant)
    else $error("Data bus driven outside a write cycle.");

  lanes_a: assert property (
    req_ready |=> byte_lane_enables_n == ~$past(req.be))
    else $error("Byte lanes do not match the request.");

  strobe_addr_a: assert property (
    (!cycle_start_strobe_n && !$rose(ctrl_oe) && $past(!cycle_start_strobe_n))
      |-> $stable(word_addr))
    else $error("Address changed while strobe asserted.");

  copro_io_a: assert property (
    (s_start and st_q.is_copro) |-> mem_io_sel == clb_pkg::SEL_IO &&
      data_ctrl_sel == clb_pkg::SEL_DATA)
    else $error("Coprocessor cycle type wrong.");

  write_hold_a: assert property (
    st_q.state == clb_pkg::CLB_T2 |-> $stable(write_read_sel))
    else $error("Write/read select changed mid-cycle.");

  wait_state_a: assert property (
    s_wait |=> st_q.state == clb_pkg::CLB_T2)
    else $error("Cycle ended without termination.");

  end_cycle_a: assert property (
    (ph_en && st_q.state == clb_pkg::CLB_T2 && !pin.ready_n) |=>
      st_q.state == clb_pkg::CLB_IDLE && $rose(rsp_valid || copro_xfer_done))
    else $error("Terminated cycle did not complete.");

  grant_float_a: assert property (
    bus_ownership_grant |-> !ctrl_oe && !data_oe && bus_lock_n)
    else $error("Outputs driven or lock held during grant.");

  grant_drop_a: assert property (
    (ph_en && bus_ownership_grant && !pin.hold) |=> !bus_ownership_grant)
    else $error("Grant not released after request withdrawn.");

  grant_idle_a: assert property (
    $rose(bus_ownership_grant) |-> $past(st_q.state) == clb_pkg::CLB_IDLE &&
      $past(bus_lock_n))
    else $error("Grant given during a cycle or lock.");

  nmi_first_a: assert property (
    (ph_en && insn_boundary && st_q.nmi_pend) |=> nmi_take && !intr_take)
    else $error("Pending NMI not taken first.");

  intr_mask_a: assert property (
    $rose(intr_take) |-> $past(intr_enable) && $past(st_q.intr_seen))
    else $error("Interrupt taken while masked or unseen.");

  stall_a: assert property (
    !pin.busy_n |-> core_stall && !req_ready)
    else $error("Busy coprocessor did not stall the core.");

  real_reset_a: assert property (
    $past(sys_rst) |-> real_mode)
    else $error("Not in real mode after reset.");

  real_limit_a: assert property (
    (s_start and real_mode and !st_q.is_copro) |->
      st_q.phys[clb_pkg::DATA_W-1:clb_pkg::REAL_W] == clb_pkg::REAL_HI_ZERO)
    else $error("Real-mode address above one megabyte.");

endmodule : clb_bus_unit

// file: tb/clb_mem_partner.sv
`timescale 1ns/1ns
module clb_mem_partner (
  input wire logic sys_clk,
  input wire logic [7:0] wait_cyc,
  input wire logic cycle_start_strobe_n,
  input wire logic ctrl_oe,
  input wire logic [clb_pkg::WADDR_W-1:0] word_addr,
  input wire logic [clb_pkg::BE_W-1:0] byte_lane_enables_n,
  input wire logic write_read_sel,
  input wire logic [clb_pkg::DATA_W-1:0] data_out,
  output logic bus_ready_n,
  output logic [clb_pkg::DATA_W-1:0] data_in
);
  logic [clb_pkg::DATA_W-1:0] mem [16];
  logic [3:0] idx;

  // Answers each started cycle after wait_cyc clocks. Ready stays low four
  // clocks, twice the two that one processing edge needs after the two-flop synchroniser, then is pulled up.
  initial begin
    bus_ready_n = 1'b1;
    data_in = 32'h0;
    foreach (mem[i]) mem[i] = 32'h0;
    forever begin
      @(posedge sys_clk);
      if (ctrl_oe && !cycle_start_strobe_n) begin
        idx = word_addr[3:0];
        for (int b = 0; b < 4; b++)
          if (write_read_sel && !byte_lane_enables_n[b])
            mem[idx][8*b+:8] = data_out[8*b+:8];
        repeat (wait_cyc) @(posedge sys_clk);
        data_in <= write_read_sel ? ~data_in : mem[idx];
        bus_ready_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        bus_ready_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        // Released lines show junk so a stale word is never mistaken.
        data_in <= ~data_in;
      end
    end
  end
endmodule : clb_mem_partner

// file: tb/clb_bus_unit_tb.sv
`timescale 1ns/1ns
module clb_bus_unit_tb;
  logic sys_clk, sys_rst, clk_en, req_valid, req_ready, rsp_valid;
  clb_pkg::clb_req_t req;
  logic [31:0] rsp_rdata, copro_wdata, data_out, data_in, s_addr, s_dout;
  logic enter_protected, real_mode, insn_boundary, intr_enable;
  logic intr_take, nmi_take, copro_xfer_write, copro_xfer_done;
  logic core_stall, copro_error, proc_phase, bus_ready_n, hold_request;
  logic intr_request, nmi_request, copro_operand_request, copro_busy_n;
  logic copro_error_n, data_oe, cycle_start_strobe_n, mem_io_sel;
  logic data_ctrl_sel, write_read_sel, bus_lock_n, ctrl_oe, grant;
  logic [29:0] word_addr;
  logic [3:0] be_n;
  logic [7:0] wait_cyc, s_ctl;
  int err_count, n_compared, ticks;

  clb_bus_unit dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .enter_protected(enter_protected), .real_mode(real_mode),
    .insn_boundary(insn_boundary), .intr_enable(intr_enable),
    .intr_take(intr_take), .nmi_take(nmi_take),
    .copro_xfer_write(copro_xfer_write), .copro_wdata(copro_wdata),
    .copro_xfer_done(copro_xfer_done), .core_stall(core_stall),
    .copro_error(copro_error), .proc_phase(proc_phase),
    .bus_ready_n(bus_ready_n), .hold_request(hold_request),
    .intr_request(intr_request), .nmi_request(nmi_request),
    .copro_operand_request(copro_operand_request),
    .copro_busy_n(copro_busy_n), .copro_error_n(copro_error_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .word_addr(word_addr), .byte_lane_enables_n(be_n),
    .cycle_start_strobe_n(cycle_start_strobe_n), .mem_io_sel(mem_io_sel),
    .data_ctrl_sel(data_ctrl_sel), .write_read_sel(write_read_sel),
    .bus_lock_n(bus_lock_n), .ctrl_oe(ctrl_oe),
    .bus_ownership_grant(grant));

  clb_mem_partner mem_side (.sys_clk(sys_clk), .wait_cyc(wait_cyc),
    .cycle_start_strobe_n(cycle_start_strobe_n), .ctrl_oe(ctrl_oe),
    .word_addr(word_addr), .byte_lane_enables_n(be_n),
    .write_read_sel(write_read_sel), .data_out(data_out),
    .bus_ready_n(bus_ready_n), .data_in(data_in));

  // The clock is 125 MHz; the hang guard is about ten times the run.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    ticks <= ticks + 1;
    if (ticks == 4000) begin
      err_count++;
      report_and_stop();
    end
  end

  // Captures the cycle pins while the start strobe is low.
  always @(negedge sys_clk) if (!cycle_start_strobe_n) begin
    s_addr <= {2'h0, word_addr};
    s_dout <= data_out;
    s_ctl <= {mem_io_sel, data_ctrl_sel, write_read_sel, bus_lock_n, be_n};
  end

  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic do_reset();
    sys_rst = 1'b1;
    cyc(16);
    sys_rst = 1'b0;
    cyc(1);
    chk({real_mode, cycle_start_strobe_n, be_n, bus_lock_n, ctrl_oe, data_oe,
      grant}, 10'h3FC);
  endtask : do_reset

  // One core cycle; kind is {write, mem, data, lock}, n counts its clocks.
  task automatic run_cycle(input logic [31:0] a, input logic [31:0] w,
      input logic [3:0] be, input logic [3:0] kind, output logic [31:0] rd,
      output int n);
    req = '{a, w, be, kind[3], kind[2], kind[1], kind[0]};
    req_valid = 1'b1;
    n = 0;
    while (!req_ready && n < 50) begin cyc(1); n++; end
    chk(req_ready, 1'b1);
    cyc(1);
    req_valid = 1'b0;
    n = 1;
    while (!rsp_valid && n < 60) begin
      chk(grant, 1'b0);
      cyc(1);
      n++;
    end
    chk(rsp_valid, 1'b1);
    rd = rsp_rdata;
  endtask : run_cycle

  task automatic refused();
    req_valid = 1'b1;
    repeat (8) begin cyc(1); chk(req_ready, 1'b0); end
    req_valid = 1'b0;
  endtask : refused

  task automatic wait_grant(input logic v);
    int n;
    n = 0;
    while (grant !== v && n < 12) begin cyc(1); n++; end
    chk(grant, v);
  endtask : wait_grant

  task automatic t_phase();
    logic p;
    p = proc_phase;
    repeat (4) begin cyc(1); chk(proc_phase, !p); p = proc_phase; end
    // With the enable low every flop, the phase included, must hold.
    clk_en = 1'b0;
    cyc(4);
    chk(proc_phase, p);
    clk_en = 1'b1;
  endtask : t_phase

  task automatic t_mem();
    logic [31:0] rd;
    logic [19:0] p;
    int n;
    p = 20'h12340 + 20'h00018;
    run_cycle(32'h12340018, 32'hCAFEF00D, 4'hF, 4'hE, rd, n);
    chk(s_addr, {14'h0, p[19:2]});
    chk(s_dout, 32'hCAFEF00D);
    chk(s_ctl, 8'hF0);
    run_cycle(32'h12340018, 32'h00001111, 4'h3, 4'hE, rd, n);
    chk(s_ctl, 8'hFC);
    run_cycle(32'h12340018, 32'h0, 4'hF, 4'h6, rd, n);
    chk(rd, 32'hCAFE1111);
    chk(n >= 3, 1'b1);
    run_cycle(32'hFFFF0010, 32'h0, 4'hF, 4'h6, rd, n);
    chk(s_addr, 32'h0);
    for (int k = 0; k < 8; k++) begin
      run_cycle(32'h00000040, 32'h0, 4'hF, {k[2:0], 1'b0}, rd, n);
      chk(s_ctl[7:5], {k[1], k[0], k[2]});
    end
    wait_cyc = 8'h08;
    run_cycle(32'h00000040, 32'h0, 4'hF, 4'h6, rd, n);
    chk(n >= 11, 1'b1);
    wait_cyc = 8'h00;
  endtask : t_mem

  task automatic t_lock();
    logic [31:0] rd;
    int n;
    run_cycle(32'h00000100, 32'h0, 4'hF, 4'h7, rd, n);
    chk(bus_lock_n, 1'b0);
    hold_request = 1'b1;
    run_cycle(32'h00000100, 32'h00000077, 4'hF, 4'hE, rd, n);
    chk(s_ctl[4], 1'b0);
    chk(bus_lock_n, 1'b1);
    wait_grant(1'b1);
    chk({ctrl_oe, data_oe}, 2'b00);
    refused();
    hold_request = 1'b0;
    wait_grant(1'b0);
    run_cycle(32'h00000100, 32'h0, 4'hF, 4'h6, rd, n);
    chk(rd, 32'h00000077);
  endtask : t_lock

  // Requests are raised four processing cycles before the boundary.
  task automatic int_case(input logic nmi, input logic intr, input logic en,
      input logic [1:0] exp);
    logic [1:0] seen;
    nmi_request = nmi;
    intr_request = intr;
    intr_enable = en;
    cyc(8);
    // The boundary is only looked at on a processing edge, so it is raised
    // in the clock just before one.
    if (proc_phase !== 1'b1) cyc(1);
    insn_boundary = 1'b1;
    seen = 2'b00;
    repeat (6) begin
      cyc(1);
      insn_boundary = 1'b0;
      seen = seen | {nmi_take, intr_take};
    end
    chk(seen, exp);
    nmi_request = 1'b0;
    intr_request = 1'b0;
    cyc(8);
  endtask : int_case

  task automatic t_copro();
    int n;
    for (int d = 0; d < 2; d++) begin
      copro_xfer_write = d[0];
      copro_wdata = 32'h13579BDF;
      copro_operand_request = 1'b1;
      n = 0;
      while (!copro_xfer_done && n < 60) begin cyc(1); n++; end
      copro_operand_request = 1'b0;
      chk(copro_xfer_done, 1'b1);
      chk(s_addr, {2'h0, clb_pkg::COPRO_DATA_PORT[31:2]});
      chk(s_ctl, {clb_pkg::SEL_IO, clb_pkg::SEL_DATA, d[0], 5'h10});
      if (d == 1) chk(s_dout, 32'h13579BDF);
      cyc(20);
    end
    copro_busy_n = 1'b0;
    copro_error_n = 1'b0;
    cyc(6);
    chk({core_stall, copro_error}, 2'b11);
    refused();
    copro_busy_n = 1'b1;
    copro_error_n = 1'b1;
    cyc(6);
    chk({core_stall, copro_error}, 2'b00);
  endtask : t_copro

  task automatic t_prot();
    logic [31:0] rd;
    int n;
    enter_protected = 1'b1;
    cyc(2);
    enter_protected = 1'b0;
    chk(real_mode, 1'b0);
    run_cycle(32'hABCD1234, 32'h0, 4'hF, 4'h6, rd, n);
    chk(s_addr, 32'h2AF3448D);
    do_reset();
  endtask : t_prot

  // Main sequence: every input gets a value at time zero.
  initial begin
    err_count = 0;
    n_compared = 0;
    ticks = 0;
    req_valid = 1'b0;
    clk_en = 1'b1;
    req = '0;
    enter_protected = 1'b0;
    insn_boundary = 1'b0;
    intr_enable = 1'b0;
    copro_xfer_write = 1'b0;
    copro_wdata = 32'h0;
    hold_request = 1'b0;
    intr_request = 1'b0;
    nmi_request = 1'b0;
    copro_operand_request = 1'b0;
    copro_busy_n = 1'b1;
    copro_error_n = 1'b1;
    wait_cyc = 8'h00;
    do_reset();
    t_phase();
    t_mem();
    t_lock();
    int_case(1'b0, 1'b1, 1'b1, 2'b01);
    int_case(1'b0, 1'b1, 1'b0, 2'b00);
    int_case(1'b1, 1'b1, 1'b1, 2'b10);
    int_case(1'b1, 1'b0, 1'b0, 2'b10);
    t_copro();
    t_prot();
    report_and_stop();
  end
endmodule : clb_bus_unit_tb
